// >>> adcs_pkg.sv
// adcs_pkg: constants, register map and state types of the conversion sequencer
// assumes one bus clock; the conversion clock arrives as a plain input pin
package adcs_pkg;
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_INSEL  = 8'h08;
  localparam logic [7:0] OFS_DBG    = 8'h0C;
  localparam logic [7:0] OFS_TRIG   = 8'h10;
  localparam logic [7:0] OFS_IENSET = 8'h14;
  localparam logic [7:0] OFS_IENCLR = 8'h18;
  localparam logic [7:0] OFS_FLAG   = 8'h1C;
  localparam logic [7:0] OFS_RESULT = 8'h20;
  localparam logic [7:0] OFS_CALIBRATION_REG  = 8'h24;
  localparam int A_RST   = 0;
  localparam int A_EN    = 1;
  localparam int B_DIFF  = 0;
  localparam int B_RES   = 1;
  localparam int B_FREE  = 3;
  localparam int B_EVT   = 4;
  localparam int B_PRE   = 5;
  localparam int T_START = 1;
  localparam int F_RDY   = 0;
  localparam int F_OVR   = 1;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_8  = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] SINGLE_EXTRA = 6'h02;
  typedef enum logic [1:0] {ADCS_IDLE, ADCS_RUN, ADCS_DONE} adcs_conv_type;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } adcs_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } adcs_axi_rsp_type;
  typedef struct packed {
    logic ck1, ck2, ck3, ev1, ev2, ev3;
    logic [11:0] d1, d2, smp, result, rdata;
    logic ctl_en, dbg_run, diff, free, evt_en;
    logic [1:0] res;
    logic [2:0] presc;
    logic [3:0] gain;
    logic [5:0] cal;
    logic [1:0] ien, flg;
    logic unread, aw_held, w_held, wlane, bvalid, rvalid, trig_pend, sampling;
    logic sh_diff, sh_free;
    logic [1:0] sh_res, bresp, rresp;
    logic [3:0] sh_gain;
    logic [7:0] awaddr, wdata, pre;
    logic [5:0] cnt;
    adcs_conv_type conv;
  } adcs_state_type;
endpackage

// >>> adcs_top.sv
// adcs_top: conversion sequencer with an AXI4-Lite register slave
// assumes conv_clk_in, event_start and adc_data_in come from outside the bus clock
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
// Function
// - halt conversion progress in debug halt unless run-in-debug is set
// - write protection blocks all registers but flags; debugger writes pass
// - resolution resets to 12 bits; 8 or 10 bits shorten conversion
// - enable bit written one enables, written zero disables
// - soft reset restores all registers except debug control, converter off
// - start bit or enabled event trigger begins a conversion
// - free-running mode restarts each conversion when the previous ends
// - each finished conversion overwrites the result register
// - result arriving while previous unread sets the overrun flag
// - ready flag rises only after the result register is loaded
// - writing one to an enable-set bit enables that source
// - conversion clock divided by prescaler sets the conversion rate
// - latency is one plus half resolution plus gain delay, less one free
// - gain delay per code and mode from the delay table
// - differential bit selects differential, else single-ended
// - both modes run single or free, ready set on every completion
// - start taken on the bus clock without waiting for a conversion clock edge, input sampled first half period
// - conversion clock and settings cross into the converter timing safely
module adcs_top
  import adcs_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire adcs_axi_req_type axi_req,
  output adcs_axi_rsp_type      axi_rsp,
  input  wire logic             conv_clk_in,
  input  wire logic             event_start,
  input  wire logic [11:0]      adc_data_in,
  input  wire logic             debug_halt,
  input  wire logic             debugger_access,
  input  wire logic             protect_en,
  output logic                  sample_hold
);
  adcs_state_type s;
  adcs_state_type next_s;
  logic edge_tick;
  logic half_tick;
  logic halted;
  logic locked;
  logic wr_go;
  logic do_rst;
  logic sw_start;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_CALIBRATION_REG);
  endfunction

  // gain delay in half divided periods; code F acts as code 1, other reserved codes act as no delay
  // gain delay table
  function automatic logic [5:0] gain_half(input logic [3:0] g, input logic d, input logic f);
    logic [5:0] h;
    h = 6'h00;
    unique case (g)
      4'h0: h = f ? 6'h00 : (d ? 6'h00 : 6'h02);
      4'h1, 4'hF: h = f ? (d ? 6'h00 : 6'h02) : (d ? 6'h01 : 6'h03);
      4'h2: h = f ? 6'h02 : (d ? 6'h02 : 6'h04);
      4'h3: h = f ? (d ? 6'h02 : 6'h04) : (d ? 6'h03 : 6'h05);
      4'h4: h = f ? 6'h04 : (d ? 6'h04 : 6'h06);
      default: h = 6'h00;
    endcase
    return h;
  endfunction

  function automatic logic [5:0] latency(input logic [1:0] r, input logic d, input logic [3:0] g,
                                         input logic f);
    logic [5:0] bits;
    bits = (r == RES_8) ? 6'h08 : ((r == RES_10) ? 6'h0A : 6'h0C);
    return bits + gain_half(g, d, f) + (f ? 6'h00 : SINGLE_EXTRA);
  endfunction

  always_comb begin
    logic [7:0] mask;
    mask = 8'h00;
    next_s = s;
    // conversion clock and analog inputs pass two flops before use
    next_s.ck1 = conv_clk_in;
    next_s.ck2 = s.ck1;
    next_s.ck3 = s.ck2;
    next_s.ev1 = event_start;
    next_s.ev2 = s.ev1;
    next_s.ev3 = s.ev2;
    next_s.d1 = adc_data_in;
    next_s.d2 = s.d1;
    edge_tick = s.ck2 & ~s.ck3;
    // half divided period every 2^(presc+1) conversion clock edges
    mask = 8'((9'h002 << s.presc) - 9'h001);
    half_tick = edge_tick && (s.pre == mask);
    // debug halt freezes progress unless run-in-debug
    halted = debug_halt & ~s.dbg_run;
    // protection applies to bus writes only, not debugger writes
    locked = protect_en & ~debugger_access;
    wr_go = s.aw_held & s.w_held & ~s.bvalid;
    do_rst = 1'b0;
    sw_start = 1'b0;
    if (axi_req.awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata = axi_req.wdata[7:0];
      next_s.wlane = axi_req.wstrb[0];
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (!mapped(s.awaddr)) begin
        next_s.bresp = RESP_SLVERR;
      end else if (locked && s.awaddr != OFS_FLAG) begin
        next_s.bresp = RESP_SLVERR;
      end else if (s.wlane) begin
        unique case (s.awaddr)
          OFS_CTRL_A: begin
            next_s.ctl_en = s.wdata[A_EN];
            do_rst = s.wdata[A_RST];
          end
          OFS_CTRL_B: begin
            next_s.diff = s.wdata[B_DIFF];
            next_s.res = s.wdata[B_RES+:2];
            next_s.free = s.wdata[B_FREE];
            next_s.evt_en = s.wdata[B_EVT];
            next_s.presc = s.wdata[B_PRE+:3];
          end
          OFS_INSEL: next_s.gain = s.wdata[3:0];
          OFS_DBG: next_s.dbg_run = s.wdata[0];
          OFS_TRIG: sw_start = s.wdata[T_START];
          // write one sets the source enable
          OFS_IENSET: next_s.ien = s.ien | s.wdata[1:0];
          OFS_IENCLR: next_s.ien = s.ien & ~s.wdata[1:0];
          OFS_FLAG: next_s.flg = s.flg & ~s.wdata[1:0];
          OFS_CALIBRATION_REG: next_s.cal = s.wdata[5:0];
          default: next_s.bresp = RESP_OKAY;
        endcase
      end
    end
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = 12'h000;
      unique case (axi_req.araddr)
        OFS_CTRL_A: next_s.rdata = {10'h000, s.ctl_en, 1'b0};
        OFS_CTRL_B: next_s.rdata = {4'h0, s.presc, s.evt_en, s.free, s.res, s.diff};
        OFS_INSEL: next_s.rdata = {8'h00, s.gain};
        OFS_DBG: next_s.rdata = {11'h000, s.dbg_run};
        OFS_IENSET, OFS_IENCLR: next_s.rdata = {10'h000, s.ien};
        OFS_FLAG: next_s.rdata = {10'h000, s.flg};
        OFS_RESULT: next_s.rdata = s.result;
        OFS_CALIBRATION_REG: next_s.rdata = {6'h00, s.cal};
        default: next_s.rdata = 12'h000;
      endcase
      if (axi_req.araddr == OFS_RESULT) begin
        next_s.unread = 1'b0;
      end
    end
    // software start or enabled event edge requests a conversion
    if (s.ctl_en && (sw_start || (s.evt_en && s.ev2 && !s.ev3))) begin
      next_s.trig_pend = 1'b1;
    end
    if (edge_tick && !halted && s.conv == ADCS_RUN) begin
      next_s.pre = half_tick ? 8'h00 : s.pre + 8'h01;
    end
    unique case (s.conv)
      ADCS_IDLE: begin
        // start on the bus clock once a request is pending, without waiting for a conversion clock edge
        if (s.ctl_en && s.trig_pend && !halted) begin
          next_s.conv = ADCS_RUN;
          next_s.trig_pend = 1'b0;
          next_s.sampling = 1'b1;
          next_s.pre = 8'h00;
          next_s.sh_res = s.res;
          next_s.sh_diff = s.diff;
          next_s.sh_gain = s.gain;
          next_s.sh_free = s.free;
          // first conversion uses the single-shot latency
          next_s.cnt = latency(s.res, s.diff, s.gain, 1'b0);
        end
      end
      ADCS_RUN: begin
        if (!s.ctl_en) begin
          next_s.conv = ADCS_IDLE;
          next_s.sampling = 1'b0;
        end else if (half_tick && !halted) begin
          next_s.cnt = s.cnt - 6'h01;
          // input held during the first half divided period
          if (s.sampling) begin
            next_s.sampling = 1'b0;
            next_s.smp = s.d2;
          end
          if (s.cnt == 6'h01) begin
            next_s.conv = ADCS_DONE;
            // new result replaces the old one
            unique case (s.sh_res)
              RES_8: next_s.result = {4'h0, s.smp[11:4]};
              RES_10: next_s.result = {2'h0, s.smp[11:2]};
              default: next_s.result = s.smp;
            endcase
          end
        end
      end
      ADCS_DONE: begin
        // ready raised one cycle after the result is loaded
        next_s.flg[F_RDY] = 1'b1;
        if (s.unread) begin
          next_s.flg[F_OVR] = 1'b1;
        end
        next_s.unread = 1'b1;
        next_s.conv = ADCS_IDLE;
        // free-running restarts at once with free latency
        if (s.sh_free && s.ctl_en) begin
          next_s.conv = ADCS_RUN;
          next_s.sampling = 1'b1;
          next_s.pre = 8'h00;
          next_s.cnt = latency(s.sh_res, s.sh_diff, s.sh_gain, 1'b1);
        end
      end
      default: next_s.conv = ADCS_IDLE;
    endcase
    // soft reset clears everything but debug control and the bus handshake
    if (do_rst) begin
      next_s.ctl_en = 1'b0;
      next_s.diff = 1'b0;
      next_s.res = RES_12;
      next_s.free = 1'b0;
      next_s.evt_en = 1'b0;
      next_s.presc = 3'h0;
      next_s.gain = 4'h0;
      next_s.cal = 6'h00;
      next_s.ien = 2'h0;
      next_s.flg = 2'h0;
      next_s.unread = 1'b0;
      next_s.result = 12'h000;
      next_s.trig_pend = 1'b0;
      next_s.sampling = 1'b0;
      next_s.conv = ADCS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  always_comb begin
    axi_rsp.awready = ~s.aw_held;
    axi_rsp.wready = ~s.w_held;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = ~s.rvalid;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = {20'h00000, s.rdata};
    axi_rsp.rresp = s.rresp;
    sample_hold = s.sampling;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ready_after_load: assert property (
    clk_en && s.conv == ADCS_DONE && !do_rst |=> s.flg[F_RDY])
    else $error("ready flag not set after result load");
  a_overrun_set: assert property (
    clk_en && s.conv == ADCS_DONE && s.unread && !do_rst |=> s.flg[F_OVR])
    else $error("overrun missed");
  a_result_stable: assert property (
    clk_en && s.conv != ADCS_RUN && !do_rst |=> $stable(s.result))
    else $error("result changed outside completion");
  a_off_no_start: assert property (
    clk_en && !s.ctl_en && s.conv == ADCS_IDLE |=> s.conv == ADCS_IDLE)
    else $error("conversion started while disabled");
  a_debug_freeze: assert property (
    clk_en && halted && s.ctl_en && s.conv == ADCS_RUN && !do_rst |=> $stable(s.cnt))
    else $error("progress during debug halt");
  a_soft_reset: assert property (
    clk_en && do_rst |=> !s.ctl_en && s.ien == 2'h0 && $stable(s.dbg_run))
    else $error("soft reset incomplete");
  a_protect_write: assert property (
    clk_en && wr_go && locked && s.awaddr != OFS_FLAG
      |=> s.bresp == RESP_SLVERR && $stable(s.ien))
    else $error("protected write accepted");
  a_ienset_sets: assert property (
    clk_en && wr_go && !locked && s.wlane && s.awaddr == OFS_IENSET && s.wdata[F_RDY]
      |=> s.ien[F_RDY])
    else $error("enable set ignored");
  a_latency_12: assert property (
    clk_en && s.conv == ADCS_IDLE && next_s.conv == ADCS_RUN && s.res == RES_12
      && s.gain == 4'h0 && s.diff && !do_rst |=> s.cnt == 6'h0E)
    else $error("single latency wrong");
  a_free_restart: assert property (
    clk_en && s.conv == ADCS_DONE && s.sh_free && s.ctl_en && !do_rst |=> s.conv == ADCS_RUN)
    else $error("free run did not restart");
  a_sample_first: assert property (
    clk_en && s.sampling && half_tick && !halted && s.ctl_en && !do_rst |=> !s.sampling)
    else $error("sampling beyond first half period");
endmodule
`default_nettype wire

// >>> adcs_afe_model.sv
// adcs_afe_model: analog front end and generic conversion clock source
// assumes the bench sets the analog input code as a plain level
`timescale 1ns/1ns
`default_nettype none
module adcs_afe_model (
  input  wire logic [11:0] code,
  output logic             conv_clk,
  output logic [11:0]      data
);
  // free-running clock; each phase outlasts a bus period so no edge is lost,
  // and an even half period keeps its edges off the bus clock's rising edges
  initial conv_clk = 1'h0;
  always #56 conv_clk = ~conv_clk;
  // analog level: may be sampled at any moment
  assign data = code;
endmodule
`default_nettype wire

// >>> adc_conversion_sequencer_test.sv
// adc_conversion_sequencer_test: register-level bench for adcs_top
// assumes adcs_afe_model supplies the conversion clock and input code
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_test;
  import adcs_pkg::*;
  logic             aclk, aresetn, ev, halt, dbga, prot, hold, cclk, ce;
  logic [11:0]      code, data;
  adcs_axi_req_type req;
  adcs_axi_rsp_type rsp;
  logic [31:0]      rv;
  logic [1:0]       rr;
  int               n_mismatch = 0;
  int               num_checks = 0;

  initial aclk = 1'h0;
  always #25 aclk = ~aclk;

  adcs_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .axi_req(req), .axi_rsp(rsp),
    .conv_clk_in(cclk), .event_start(ev), .adc_data_in(data), .debug_halt(halt),
    .debugger_access(dbga), .protect_en(prot), .sample_hold(hold));
  adcs_afe_model afe (.code(code), .conv_clk(cclk), .data(data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // readies sampled at the falling edge: stable until the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge aclk);
    req <= '{1'h1, a, 1'h1, d, 4'hF, 1'h1, 1'h0, 8'h00, 1'h0};
    for (int i = 0; i < 100 && !b; i++) begin
      @(negedge aclk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      rr = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'h0;
      if (w) req.wvalid <= 1'h0;
      if (b) req.bready <= 1'h0;
    end
    chk(b, 1'h1);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 1'h0;
    @(posedge aclk);
    req <= '{1'h0, 8'h00, 1'h0, 32'h0, 4'h0, 1'h0, 1'h1, a, 1'h1};
    for (int i = 0; i < 100 && !r; i++) begin
      @(negedge aclk);
      ar = req.arvalid && rsp.arready;
      r = rsp.rvalid;
      rv = rsp.rdata;
      rr = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'h0;
      if (r) req.rready <= 1'h0;
    end
    chk(r, 1'h1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] s);
    rd(a);
    chk(rv, e);
    chk(rr, s);
  endtask

  // timing resolution is one read cycle, so only relations are judged
  task automatic poll(output int cyc);
    time t0;
    t0 = $time;
    rv = 32'h0;
    for (int i = 0; i < 400 && rv[F_RDY] !== 1'h1; i++) rd(OFS_FLAG);
    cyc = int'(($time - t0) / 50);
    chk(rv[F_RDY], 1'h1);
  endtask

  task automatic conv(output int cyc);
    wr(OFS_FLAG, 32'h3);
    wr(OFS_TRIG, 32'h2);
    poll(cyc);
  endtask

  task automatic t_reset;
    rdc(OFS_CTRL_B, 32'h0, RESP_OKAY);
    rdc(OFS_FLAG, 32'h0, RESP_OKAY);
    rdc(8'h28, 32'h0, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_single;
    int c;
    wr(OFS_CALIBRATION_REG, 32'h3F);
    wr(OFS_CTRL_A, 32'h2);
    rdc(OFS_CTRL_A, 32'h2, RESP_OKAY);
    conv(c);
    rd(OFS_RESULT);
    code <= 12'hABC;
    conv(c);
    rdc(OFS_RESULT, 32'hABC, RESP_OKAY);
    rdc(OFS_FLAG, 32'h1, RESP_OKAY);
    conv(c);
    code <= 12'h456;
    wr(OFS_FLAG, 32'h1);
    wr(OFS_TRIG, 32'h2);
    poll(c);
    rdc(OFS_FLAG, 32'h3, RESP_OKAY);
    rdc(OFS_RESULT, 32'h456, RESP_OKAY);
    $display("test single done");
  endtask

  task automatic t_time;
    int c12, c8, c;
    wr(OFS_CTRL_B, 32'h40);
    conv(c12);
    wr(OFS_CTRL_B, 32'h42);
    conv(c8);
    rdc(OFS_RESULT, 32'h45, RESP_OKAY);
    chk(c8 < c12, 1'h1);
    wr(OFS_CTRL_B, 32'h44);
    conv(c);
    rdc(OFS_RESULT, 32'h115, RESP_OKAY);
    chk(c > c8 && c < c12, 1'h1);
    wr(OFS_CTRL_B, 32'h60);
    conv(c);
    chk(c > c12, 1'h1);
    wr(OFS_CTRL_B, 32'h41);
    conv(c);
    chk(c < c12, 1'h1);
    wr(OFS_INSEL, 32'h4);
    wr(OFS_CTRL_B, 32'h40);
    conv(c);
    chk(c > c12, 1'h1);
    wr(OFS_INSEL, 32'h0);
    $display("test timing done");
  endtask

  task automatic t_free;
    int c;
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL_B, 32'h8 | 32'(i));
      wr(OFS_CTRL_A, 32'h2);
      conv(c);
      wr(OFS_FLAG, 32'h3);
      poll(c);
      wr(OFS_CTRL_A, 32'h0);
    end
    wr(OFS_FLAG, 32'h3);
    repeat (300) @(posedge aclk);
    rdc(OFS_FLAG, 32'h0, RESP_OKAY);
    $display("test free done");
  endtask

  task automatic t_event;
    int c;
    wr(OFS_CTRL_B, 32'h10);
    wr(OFS_CTRL_A, 32'h2);
    ev <= 1'h1;
    poll(c);
    ev <= 1'h0;
    $display("test event done");
  endtask

  task automatic t_prot;
    prot <= 1'h1;
    wr(OFS_CTRL_B, 32'h2);
    chk(rr, RESP_SLVERR);
    rdc(OFS_CTRL_B, 32'h10, RESP_OKAY);
    wr(OFS_FLAG, 32'h3);
    chk(rr, RESP_OKAY);
    dbga <= 1'h1;
    wr(OFS_CTRL_B, 32'h2);
    rdc(OFS_CTRL_B, 32'h2, RESP_OKAY);
    {prot, dbga} <= 2'h0;
    $display("test protect done");
  endtask

  task automatic t_debug;
    int c;
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_FLAG, 32'h3);
    wr(OFS_TRIG, 32'h2);
    // halt lands in the first cycle of the conversion, before any half period ends
    halt <= 1'h1;
    repeat (300) @(posedge aclk);
    chk(hold, 1'h1);
    rdc(OFS_FLAG, 32'h0, RESP_OKAY);
    halt <= 1'h0;
    poll(c);
    chk(hold, 1'h0);
    wr(OFS_DBG, 32'h1);
    halt <= 1'h1;
    conv(c);
    halt <= 1'h0;
    wr(OFS_FLAG, 32'h3);
    wr(OFS_TRIG, 32'h2);
    ce <= 1'h0;
    repeat (300) @(posedge aclk);
    chk(hold, 1'h1);
    ce <= 1'h1;
    rdc(OFS_FLAG, 32'h0, RESP_OKAY);
    poll(c);
    $display("test debug done");
  endtask

  task automatic t_soft_reset_bit;
    wr(OFS_IENSET, 32'h3);
    rdc(OFS_IENSET, 32'h3, RESP_OKAY);
    wr(OFS_CTRL_B, 32'h1A);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CTRL_A, 32'h1);
    rdc(OFS_CTRL_B, 32'h0, RESP_OKAY);
    rdc(OFS_IENSET, 32'h0, RESP_OKAY);
    rdc(OFS_CALIBRATION_REG, 32'h0, RESP_OKAY);
    rdc(OFS_RESULT, 32'h0, RESP_OKAY);
    rdc(OFS_DBG, 32'h1, RESP_OKAY);
    rdc(OFS_CTRL_A, 32'h0, RESP_OKAY);
    $display("test soft reset done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    {aresetn, ev, halt, dbga, prot} = 5'h00;
    ce = 1'h1;
    req = '0;
    code = 12'h000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_single();
    t_time();
    t_free();
    t_event();
    t_prot();
    t_debug();
    t_soft_reset_bit();
    print_verdict();
  end

  // far above the expected run length of a few thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
